// file: adc_defs.vh
// Constants of the accessory detect control block.
// Assumes inclusion by adc_ctrl.v only; definitions only.
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// ****************************************
// Serial slave
// ****************************************
`define ADC_SLAVE_ADDR 7'h25
`define ADC_SCL_MAX_KHZ 400

// ****************************************
// Register offsets
// ****************************************
`define ADC_R_CTRL 8'h02
`define ADC_R_INT 8'h03
`define ADC_R_CODE 8'h07
`define ADC_R_DTYPE 8'h0a
`define ADC_R_MSW 8'h13
`define ADC_R_SRST 8'h1b

// ****************************************
// Fields and reset values
// ****************************************
`define ADC_CTRL_MASK 0
`define ADC_CTRL_AUTO 2
`define ADC_CTRL_RST 8'h05
`define ADC_MSW_RST 8'h00
`define ADC_SRST_BIT 0
`define ADC_INT_ATT 0
`define ADC_INT_DET 1
`define ADC_INT_VBUS 2

// ****************************************
// Accessory codes and classes
// ****************************************
`define ADC_CODE_UNK0 5'h15
`define ADC_CODE_UNK1 5'h16
`define ADC_CODE_TRAVEL_ADAPTER 5'h17
`define ADC_CODE_USB_OFF 5'h18
`define ADC_CODE_USB_ON 5'h19
`define ADC_CODE_UNK2 5'h1a
`define ADC_CODE_UNK3 5'h1b
`define ADC_CODE_UART_OFF 5'h1c
`define ADC_CODE_UART_ON 5'h1d
`define ADC_CODE_UNK4 5'h1e
`define ADC_CODE_OPEN 5'h1f
`define ADC_DT_TRAVEL_ADAPTER 0
`define ADC_DT_USB_OFF 1
`define ADC_DT_USB_ON 2
`define ADC_DT_UART_OFF 3
`define ADC_DT_UART_ON 4
`define ADC_DT_UNK 5

// ****************************************
// Switch paths
// ****************************************
`define ADC_SW_OPEN 2'h0
`define ADC_SW_USB 2'h1
`define ADC_SW_UART 2'h2

`endif

// file: adc_ctrl.v
// Control logic of a USB port accessory detector: supply gating, resets,
// serial register slave, switch and charger selection, ID code reporting.
// Assumes all inputs synchronous to i_clk_sys and an ID converter outside.
`timescale 1ns/1ps
`include "adc_defs.vh"

module adc_ctrl
(
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_bat_valid,
  input wire i_vbus_valid,
  input wire i_host_io_supply,
  input wire i_scl,
  input wire i_sda,
  input wire i_id_valid,
  input wire [4:0] i_id_code,
  output reg o_sda,
  output reg o_sda_oe_n,
  output reg o_int_n,
  output reg [1:0] o_sw_path,
  output reg o_chg_en,
  output reg o_chg_hi
);

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_REG = 3'd2;
  localparam S_WR = 3'd3;
  localparam S_ACK = 3'd4;
  localparam S_RD = 3'd5;
  localparam S_RACK = 3'd6;

  // ****************************************
  // Functions
  // ****************************************
  function [7:0] dev_class;
    input [4:0] code;
    input vbus;
    begin
      dev_class = 8'h00;
      case (code)
        `ADC_CODE_TRAVEL_ADAPTER: dev_class[`ADC_DT_TRAVEL_ADAPTER] = vbus;
        `ADC_CODE_USB_OFF: dev_class[`ADC_DT_USB_OFF] = 1'b1;
        `ADC_CODE_USB_ON: dev_class[`ADC_DT_USB_ON] = 1'b1;
        `ADC_CODE_UART_OFF: dev_class[`ADC_DT_UART_OFF] = 1'b1;
        `ADC_CODE_UART_ON: dev_class[`ADC_DT_UART_ON] = 1'b1;
        `ADC_CODE_OPEN: dev_class = 8'h00;
        default: dev_class[`ADC_DT_UNK] = 1'b1;
      endcase
    end
  endfunction

  function [1:0] auto_path;
    input [7:0] dt;
    begin
      if (dt[`ADC_DT_USB_OFF] | dt[`ADC_DT_USB_ON])
        auto_path = `ADC_SW_USB;
      else if (dt[`ADC_DT_UART_OFF] | dt[`ADC_DT_UART_ON])
        auto_path = `ADC_SW_UART;
      else
        auto_path = `ADC_SW_OPEN;
    end
  endfunction

  // ****************************************
  // Supplies and resets
  // ****************************************
  reg bat_q;
  reg vbus_q;
  reg por;
  reg sw_rst;
  wire rst_all;
  wire com_en;

  // Power-on pulse only when leaving the fully unpowered state
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      bat_q <= 1'b0;
      vbus_q <= 1'b0;
      por <= 1'b0;
    end
    else
    begin
      bat_q <= i_bat_valid;
      vbus_q <= i_vbus_valid;
      por <= (i_bat_valid | i_vbus_valid) & ~bat_q & ~vbus_q;
    end
  end

  assign rst_all = i_sys_rst | por | sw_rst;
  assign com_en = i_bat_valid & i_host_io_supply;

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] ctrl;
  reg [7:0] msw;
  reg [7:0] int_st;
  reg [4:0] id_code;
  reg [7:0] dtype;
  reg vbus_seen;
  reg [7:0] ptr;
  reg wr_stb;
  reg [7:0] wr_data;
  reg [7:0] wr_addr;
  reg rd_clr;
  reg [7:0] int_set;

  function [7:0] rd_reg;
    input [7:0] a;
    begin
      case (a)
        `ADC_R_CTRL: rd_reg = ctrl;
        `ADC_R_INT: rd_reg = int_st;
        `ADC_R_CODE: rd_reg = {3'h0, id_code};
        `ADC_R_DTYPE: rd_reg = dtype;
        `ADC_R_MSW: rd_reg = msw;
        default: rd_reg = 8'h00;
      endcase
    end
  endfunction

  always @*
  begin
    int_set = 8'h00;
    if (i_bat_valid & i_id_valid)
    begin
      int_set[`ADC_INT_ATT] = (i_id_code != `ADC_CODE_OPEN);
      int_set[`ADC_INT_DET] = (i_id_code == `ADC_CODE_OPEN) & (id_code != `ADC_CODE_OPEN);
    end
    int_set[`ADC_INT_VBUS] = i_bat_valid & (i_vbus_valid != vbus_seen);
  end

  // Standby after reset: code reads open, no class, switches open
  always @(posedge i_clk_sys)
  begin
    if (rst_all)
    begin
      ctrl <= `ADC_CTRL_RST;
      msw <= `ADC_MSW_RST;
      int_st <= 8'h00;
      id_code <= `ADC_CODE_OPEN;
      dtype <= 8'h00;
      vbus_seen <= 1'b0;
      sw_rst <= 1'b0;
    end
    else
    begin
      sw_rst <= wr_stb & (wr_addr == `ADC_R_SRST) &
        wr_data[`ADC_SRST_BIT];
      if (wr_stb & (wr_addr == `ADC_R_CTRL))
        ctrl <= wr_data;
      if (wr_stb & (wr_addr == `ADC_R_MSW))
        msw <= wr_data;
      // A new event beats a read-clear in the same cycle
      int_st <= (int_st & ~(rd_clr ? 8'hff : 8'h00)) | int_set;
      if (i_bat_valid)
        vbus_seen <= i_vbus_valid;
      if (i_bat_valid & i_id_valid)
      begin
        id_code <= i_id_code;
        dtype <= dev_class(i_id_code, i_vbus_valid);
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge i_clk_sys)
  begin
    if (rst_all)
    begin
      o_int_n <= 1'b1;
      o_sw_path <= `ADC_SW_OPEN;
      o_chg_en <= 1'b0;
      o_chg_hi <= 1'b0;
    end
    else
    begin
      o_int_n <= ~(com_en & ~ctrl[`ADC_CTRL_MASK] & (|int_st));
      if (~i_bat_valid)
        o_sw_path <= `ADC_SW_OPEN;
      else if (ctrl[`ADC_CTRL_AUTO])
        o_sw_path <= auto_path(dtype);
      else
        o_sw_path <= (msw[1:0] == 2'h3) ? `ADC_SW_OPEN : msw[1:0];
      o_chg_en <= i_vbus_valid;
      o_chg_hi <= i_vbus_valid & dtype[`ADC_DT_TRAVEL_ADAPTER];
    end
  end

  // ****************************************
  // Serial slave
  // ****************************************
  // Sampled at 100 MHz; 400 kHz bus leaves 250 samples per bit
  reg scl_q;
  reg sda_q;
  reg [2:0] st;
  reg [2:0] ack_next;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg [7:0] tx;
  reg nack;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;

  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign start_c = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_c = i_scl & scl_q & ~sda_q & i_sda;

  always @(posedge i_clk_sys)
  begin
    if (rst_all | ~com_en)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st <= S_IDLE;
      ack_next <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'hff;
      nack <= 1'b0;
      o_sda <= 1'b0;
      o_sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      wr_addr <= 8'h00;
      rd_clr <= 1'b0;
      if (rst_all)
        ptr <= 8'h00;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      if (start_c)
      begin
        st <= S_ADDR;
        cnt <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end
      else if (stop_c)
      begin
        st <= S_IDLE;
        o_sda_oe_n <= 1'b1;
      end
      else if (scl_rise)
      begin
        case (st)
          S_ADDR, S_REG, S_WR:
          begin
            sh <= {sh[6:0], i_sda};
            cnt <= cnt + 4'h1;
          end
          S_RACK: nack <= i_sda;
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (st)
          S_ADDR:
            if (cnt == 4'h8)
            begin
              if (sh[7:1] == `ADC_SLAVE_ADDR)
              begin
                st <= S_ACK;
                o_sda_oe_n <= 1'b0;
                ack_next <= sh[0] ? S_RD : S_REG;
              end
              else
                st <= S_IDLE;
            end
          S_REG:
            if (cnt == 4'h8)
            begin
              ptr <= sh;
              st <= S_ACK;
              o_sda_oe_n <= 1'b0;
              ack_next <= S_WR;
            end
          S_WR:
            if (cnt == 4'h8)
            begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= sh;
              ptr <= ptr + 8'h01;
              st <= S_ACK;
              o_sda_oe_n <= 1'b0;
              ack_next <= S_WR;
            end
          S_ACK, S_RACK:
          begin
            cnt <= 4'h0;
            if ((st == S_ACK) & (ack_next != S_RD))
            begin
              o_sda_oe_n <= 1'b1;
              st <= ack_next;
            end
            else if ((st == S_RACK) & nack)
            begin
              o_sda_oe_n <= 1'b1;
              st <= S_IDLE;
            end
            else
            begin
              // Read continues from the current pointer
              {o_sda_oe_n, tx[6:0]} <= rd_reg(ptr);
              rd_clr <= (ptr == `ADC_R_INT);
              ptr <= ptr + 8'h01;
              cnt <= 4'h1;
              st <= S_RD;
            end
          end
          S_RD:
            if (cnt == 4'h8)
            begin
              o_sda_oe_n <= 1'b1;
              st <= S_RACK;
            end
            else
            begin
              o_sda_oe_n <= tx[6];
              tx <= {tx[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

endmodule // adc_ctrl

// file: acd_properties.sv
// Port assertions for the accessory detect control block.
// Assumes one clock, i_clk_sys, and synchronous active-high i_sys_rst.
`timescale 1ns/1ps
module adc_props
(
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_bat_valid,
  input wire i_vbus_valid,
  input wire i_host_io_supply,
  input wire i_scl,
  input wire o_sda,
  input wire o_sda_oe_n,
  input wire o_int_n,
  input wire [1:0] o_sw_path,
  input wire o_chg_en,
  input wire o_chg_hi
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_reset_outputs_idle: assert property ($fell(i_sys_rst) |-> o_int_n && o_sda_oe_n
    && o_sw_path == 2'h0 && !o_chg_en && !o_chg_hi) else $error("outputs busy after reset");
  a_chg_off_novbus: assert property (!$past(i_vbus_valid) |-> !o_chg_en)
    else $error("charger on without bus supply");
  a_quiet_unpowered: assert property (!(i_bat_valid && i_host_io_supply) [*2]
    |-> o_sda_oe_n && o_int_n) else $error("serial port or interrupt active unpowered");
  a_int_needs_power: assert property ($fell(o_int_n)
    |-> $past(i_bat_valid) && $past(i_host_io_supply)) else $error("interrupt unpowered");
  a_path_open_nobat: assert property (!i_bat_valid [*3] |-> o_sw_path == 2'h0)
    else $error("switch closed without battery");
  a_path_legal: assert property (o_sw_path != 2'h3)
    else $error("undefined switch path");
  a_data_open_drain: assert property (o_sda == 1'b0)
    else $error("data line driven high");
  a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !$past(i_scl))
    else $error("data pulled while clock high");
endmodule // adc_props

bind adc_ctrl adc_props u_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_bat_valid(i_bat_valid), .i_vbus_valid(i_vbus_valid),
  .i_host_io_supply(i_host_io_supply), .i_scl(i_scl), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n), .o_int_n(o_int_n), .o_sw_path(o_sw_path),
  .o_chg_en(o_chg_en), .o_chg_hi(o_chg_hi));

// file: acd_host.sv
// Serial bus master standing in for the phone processor.
// Assumes a pulled-up data wire resolved outside; low enable pulls it.
`timescale 1ns/1ps
module adc_host
(
  input wire i_clk,
  input wire i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  // Quarter bit of 63 clocks keeps the clock just under 400 kHz
  localparam int Q = 63;
  logic [6:0] addr7;
  logic [2:0] acks;
  logic [7:0] got [4];
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
    addr7 = 7'h25;
  end
  task tk(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bitx(input logic b, output logic r);
    o_sda_oe_n <= b;
    tk(Q);
    o_scl <= 1'b1;
    tk(Q);
    r = i_sda;
    tk(Q);
    o_scl <= 1'b0;
    tk(Q);
  endtask
  task sendb(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    a = !r;
  endtask
  task start();
    tk(Q);
    o_sda_oe_n <= 1'b0;
    tk(Q);
    o_scl <= 1'b0;
    tk(Q);
  endtask
  task stop();
    o_sda_oe_n <= 1'b0;
    tk(Q);
    o_scl <= 1'b1;
    tk(Q);
    o_sda_oe_n <= 1'b1;
    tk(Q);
  endtask
  // n is the count of bytes after the address: pointer, then data
  task wr(input logic [7:0] ra, input logic [7:0] d, input int n);
    logic a;
    acks = 3'h0;
    start();
    sendb({addr7, 1'b0}, a);
    acks[2] = a;
    if (n > 0) sendb(ra, a);
    if (n > 0) acks[1] = a;
    if (n > 1) sendb(d, a);
    if (n > 1) acks[0] = a;
    stop();
  endtask
  task rd(input int n);
    logic a;
    logic r;
    start();
    sendb({addr7, 1'b1}, a);
    acks[2] = a;
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bitx(1'b1, r);
        got[k][i] = r;
      end
      bitx(k == n - 1, r);
    end
    stop();
  endtask
endmodule // adc_host

// file: testbench.sv
// Self-checking bench for the accessory detect control block.
// Assumes the checker is bound in and the host model drives the serial bus.
`timescale 1ns/1ps
module testbench;
  logic clk, rst, bat, vbus, io, id_valid;
  logic [4:0] id_code;
  wire o_sda, o_sda_oe_n, o_int_n, o_chg_en, o_chg_hi, scl, m_oe_n;
  wire [1:0] o_sw_path;
  // Pull-up wire: either party pulling low wins
  wire sda = m_oe_n & (o_sda_oe_n | o_sda);
  wire [7:0] outs = {1'b0, o_sda, o_int_n, o_sda_oe_n, o_sw_path, o_chg_en, o_chg_hi};
  int miscompares = 0;
  int n_checks = 0;
  logic [4:0] cd [11] = '{5'h17, 5'h18, 5'h19, 5'h1c, 5'h1d, 5'h15, 5'h16, 5'h1a, 5'h1b,
    5'h1f, 5'h1e};
  logic [7:0] ex [11] = '{8'h33, 8'h36, 8'h36, 8'h3a, 8'h3a, 8'h32, 8'h32, 8'h32, 8'h32,
    8'h32, 8'h32};
  adc_ctrl uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_bat_valid(bat), .i_vbus_valid(vbus),
    .i_host_io_supply(io), .i_scl(scl), .i_sda(sda), .i_id_valid(id_valid),
    .i_id_code(id_code), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_int_n(o_int_n),
    .o_sw_path(o_sw_path), .o_chg_en(o_chg_en), .o_chg_hi(o_chg_hi));
  adc_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));
  // ****
  // Helpers
  // ****
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task det(input logic [4:0] c);
    id_code <= c;
    id_valid <= 1'b1;
    @(posedge clk);
    id_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    rst = 1'b1;
    bat = 1'b1;
    vbus = 1'b0;
    io = 1'b1;
    id_valid = 1'b0;
    id_code = 5'h1f;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("reset outs", outs, 8'h30);
    vbus <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      det(cd[i]);
      chk("class outs", outs, ex[i]);
    end
    host.wr(8'h07, 8'h00, 1);
    host.rd(4);
    chk("code", host.got[0], 8'h1e);
    chk("unmapped", host.got[1] | host.got[2], 8'h00);
    chk("type", host.got[3], 8'h20);
    host.wr(8'h02, 8'h04, 2);
    chk("acks", {5'h0, host.acks}, 8'h07);
    chk("unmasked", outs, 8'h12);
    host.wr(8'h03, 8'h00, 1);
    host.rd(1);
    chk("events", host.got[0], 8'h07);
    chk("cleared", outs, 8'h32);
    host.wr(8'h02, 8'h00, 2);
    host.wr(8'h13, 8'h02, 2);
    chk("manual", outs, 8'h3a);
    host.wr(8'h1b, 8'h01, 2);
    chk("soft reset", outs, 8'h32);
    host.wr(8'h02, 8'h00, 1);
    host.rd(1);
    chk("control", host.got[0], 8'h05);
    host.addr7 = 7'h24;
    host.wr(8'h00, 8'h00, 0);
    chk("wrong addr", {5'h0, host.acks}, 8'h00);
    host.addr7 = 7'h25;
    io <= 1'b0;
    host.wr(8'h00, 8'h00, 0);
    chk("no io", {5'h0, host.acks}, 8'h00);
    io <= 1'b1;
    det(5'h18);
    chk("usb path", outs, 8'h36);
    bat <= 1'b0;
    repeat (5) @(posedge clk);
    chk("no battery", outs, 8'h32);
    vbus <= 1'b0;
    io <= 1'b0;
    repeat (5) @(posedge clk);
    bat <= 1'b1;
    io <= 1'b1;
    repeat (8) @(posedge clk);
    chk("power on", outs, 8'h30);
    det(5'h1c);
    chk("battery only", outs, 8'h38);
    complete_run();
  end
endmodule // testbench
